// ### dv/reg_host.sv
/*
 * Host model that reaches the register bank over Avalon-MM, one request at a time.
 * Assumes the slave runs on clk and answers by dropping waitrequest for one cycle.
 */
module reg_host (
	input  wire logic        clk,
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic [1:0]  avs_response
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		avs_address = 8'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end

	// Released address and write data lines get inverted so a slave that keeps using them shows up.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd, output logic [1:0] rs, output logic to);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		to = 1'h1;
		rd = 32'h0;
		rs = 2'h0;
		for (int n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'h0)
			begin
				rd = avs_readdata;
				rs = avs_response;
				to = 1'h0;
				break;
			end
		end
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
endmodule

// ### dv/tb_channel1_config_calib_regs.sv
/*
 * Self-checking bench for the second channel register bank, with a host model on its bus.
 * Assumes the slave answers each request within a few cycles and walks the checksum in under ten.
 */
module tb_channel1_config_calib_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        sys_rst;
	logic [7:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  avs_response;
	logic [3:0]  global_highpass_setting;
	logic [9:0]  second_channel_phase_delay;
	logic        second_channel_highpass_disable;
	logic [3:0]  second_channel_highpass_setting;
	logic [1:0]  second_channel_input_select;
	logic [23:0] second_channel_offset;
	logic [23:0] second_channel_gain;
	logic [15:0] register_map_checksum;
	logic        checksum_busy;
	logic [15:0] mdl [6];
	logic        changed;
	logic [31:0] rd;
	logic [1:0]  rs;
	int          seed;
	int          err_count;
	int          checks_done;

	localparam logic [7:0]  SLOT_ADDR [6] = '{8'h38, 8'h3c, 8'h40, 8'h44, 8'h48, 8'hfc};
	localparam logic [15:0] SLOT_MASK [6] = '{16'hffc7, 16'hffff, 16'hff00, 16'hffff, 16'hff00, 16'hffff};

	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	channel1_config_calib_regs channel1_config_calib_regs_i (.clk(clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .global_highpass_setting(global_highpass_setting),
		.second_channel_phase_delay(second_channel_phase_delay),
		.second_channel_highpass_disable(second_channel_highpass_disable),
		.second_channel_highpass_setting(second_channel_highpass_setting),
		.second_channel_input_select(second_channel_input_select), .second_channel_offset(second_channel_offset),
		.second_channel_gain(second_channel_gain), .register_map_checksum(register_map_checksum),
		.checksum_busy(checksum_busy));

	reg_host reg_host_i (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response));

	task automatic report_and_stop();
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	// Expected checksum, worked out bit by bit over the modelled words.
	function automatic logic [15:0] crc_of();
		logic [15:0] c;
		logic        fb;
		c = ch1_regs_pkg::CRC_INIT;
		for (int w = 0; w < 6; w++)
			for (int b = 15; b >= 0; b--)
			begin
				fb = c[15] ^ mdl[w][b];
				c = {c[14:0], 1'h0} ^ (fb ? ch1_regs_pkg::CRC_POLY : 16'h0000);
			end
		return c;
	endfunction

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		logic to;
		reg_host_i.xfer(wr, a, d, be, rd, rs, to);
		if (to !== 1'h0)
		begin
			err_count++;
			report_and_stop();
		end
	endtask

	task automatic check_outputs();
		check({22'h0, second_channel_phase_delay}, {22'h0, mdl[0][15:6]});
		check({31'h0, second_channel_highpass_disable}, {31'h0, mdl[0][2]});
		check({30'h0, second_channel_input_select}, {30'h0, mdl[0][1:0]});
		check({8'h0, second_channel_offset}, {8'h0, mdl[1], mdl[2][15:8]});
		check({8'h0, second_channel_gain}, {8'h0, mdl[3], mdl[4][15:8]});
		check({16'h0, register_map_checksum}, {16'h0, changed ? crc_of() : 16'h0000});
		check({31'h0, checksum_busy}, 32'h0);
	endtask

	task automatic read_all();
		for (int i = 0; i < 6; i++)
		begin
			bus(1'h0, SLOT_ADDR[i], 32'h0, 4'hf);
			check(rd, {16'h0, mdl[i]});
			check({30'h0, rs}, 32'h0);
		end
		bus(1'h0, 8'hf8, 32'h0, 4'hf);
		check(rd, {16'h0, changed ? crc_of() : 16'h0000});
	endtask

	task automatic wr_slot(input int i, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] m;
		logic [15:0] nv;
		m = SLOT_MASK[i] & {{8{be[1]}}, {8{be[0]}}};
		nv = (mdl[i] & ~m) | (d[15:0] & m);
		bus(1'h1, SLOT_ADDR[i], d, be);
		check({30'h0, rs}, 32'h0);
		if (nv !== mdl[i])
			changed = 1'h1;
		mdl[i] = nv;
		repeat (10) @(posedge clk);
		check_outputs();
	endtask

	// The bench model resets alongside the design, so a mid-run reset is checked the same way.
	task automatic do_reset();
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'h0;
		changed = 1'h0;
		mdl = '{ch1_regs_pkg::RST_CONFIG, ch1_regs_pkg::RST_OFFSET_UPPER, ch1_regs_pkg::RST_OFFSET_LOWER,
			ch1_regs_pkg::RST_GAIN_UPPER, ch1_regs_pkg::RST_GAIN_LOWER, ch1_regs_pkg::RST_RESERVED};
		@(posedge clk);
		check_outputs();
		read_all();
	endtask

	initial
	begin
		seed = 54;
		err_count = 0;
		checks_done = 0;
		sys_rst = 1'h1;
		global_highpass_setting = 4'h0;
		do_reset();
		bus(1'h0, 8'h4c, 32'h0, 4'hf);
		check(rd, 32'h0);
		check({30'h0, rs}, 32'h3);
		bus(1'h1, 8'h00, 32'hffffffff, 4'hf);
		bus(1'h1, 8'hf8, 32'h00001234, 4'hf);
		check({30'h0, rs}, 32'h0);
		read_all();
		for (int i = 0; i < 6; i++)
			wr_slot(i, 32'hffffffff, 4'hf);
		read_all();
		// Every input code, with the filter disable toggled and the most negative phase.
		for (int k = 0; k < 4; k++)
		begin
			wr_slot(0, {16'h0, 10'h200, 3'h7, k[0], k[1:0]}, 4'h3);
			for (int j = 0; j < 4; j++)
			begin
				global_highpass_setting <= 4'($random(seed));
				@(posedge clk);
				@(posedge clk);
				check({28'h0, second_channel_highpass_setting}, {28'h0, mdl[0][2] ? 4'h0 : global_highpass_setting});
			end
		end
		for (int n = 0; n < 80; n++)
		begin
			global_highpass_setting <= 4'($random(seed));
			wr_slot(int'($unsigned($random(seed)) % 6), $random(seed), 4'($random(seed)));
			if (n % 20 == 19)
				read_all();
		end
		do_reset();
		wr_slot(3, 32'h0000007f, 4'h1);
		read_all();
		report_and_stop();
	end
endmodule

// ### logic/ch1_regs_pkg.sv
/*
 * Constants for the second channel configuration and calibration register bank.
 * Assumes a 32-bit Avalon-MM slave with byte addressing, one register per aligned word.
 */
package ch1_regs_pkg;

	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int WORD_W     = 16;
	localparam int SLOT_COUNT = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_CONFIG       = 6'h0e;
	localparam logic [5:0] IDX_OFFSET_UPPER = 6'h0f;
	localparam logic [5:0] IDX_OFFSET_LOWER = 6'h10;
	localparam logic [5:0] IDX_GAIN_UPPER   = 6'h11;
	localparam logic [5:0] IDX_GAIN_LOWER   = 6'h12;
	localparam logic [5:0] IDX_CHECKSUM     = 6'h3e;
	localparam logic [5:0] IDX_RESERVED     = 6'h3f;

	// Storage slots of the writable words.
	localparam logic [2:0] SLOT_CONFIG       = 3'h0;
	localparam logic [2:0] SLOT_OFFSET_UPPER = 3'h1;
	localparam logic [2:0] SLOT_OFFSET_LOWER = 3'h2;
	localparam logic [2:0] SLOT_GAIN_UPPER   = 3'h3;
	localparam logic [2:0] SLOT_GAIN_LOWER   = 3'h4;
	localparam logic [2:0] SLOT_RESERVED     = 3'h5;
	localparam logic [2:0] SLOT_NONE         = 3'h7;

	// Reset values.
	localparam logic [15:0] RST_CONFIG       = 16'h0000;
	localparam logic [15:0] RST_OFFSET_UPPER = 16'h0000;
	localparam logic [15:0] RST_OFFSET_LOWER = 16'h0000;
	localparam logic [15:0] RST_GAIN_UPPER   = 16'h8000;
	localparam logic [15:0] RST_GAIN_LOWER   = 16'h0000;
	localparam logic [15:0] RST_RESERVED     = 16'h0000;
	localparam logic [15:0] RST_CHECKSUM     = 16'h0000;

	// Writable bits of each word; the others read as zero.
	localparam logic [15:0] MASK_CONFIG = 16'hffc7;
	localparam logic [15:0] MASK_FULL   = 16'hffff;
	localparam logic [15:0] MASK_LOWER  = 16'hff00;

	// Field positions.
	localparam int PHASE_MSB      = 15;
	localparam int PHASE_LSB      = 6;
	localparam int HP_DISABLE_BIT = 2;
	localparam int SEL_MSB        = 1;
	localparam int SEL_LSB        = 0;
	localparam int LOWER_MSB      = 15;
	localparam int LOWER_LSB      = 8;

	// Input selection codes.
	localparam logic [1:0] SEL_NORMAL   = 2'h0;
	localparam logic [1:0] SEL_SHORTED  = 2'h1;
	localparam logic [1:0] SEL_POS_TEST = 2'h2;
	localparam logic [1:0] SEL_NEG_TEST = 2'h3;

	localparam logic [3:0] HP_OFF = 4'h0;

	// Checksum polynomial and seed.
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;

	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_DECODEERROR = 2'h3;

endpackage

// ### logic/channel1_config_calib_regs.sv
/*
 * Second channel configuration and calibration register bank behind an Avalon-MM slave.
 * Assumes a master on the same clock that holds each request until waitrequest is seen low.
 */
// Added by the designer: the Avalon-MM register port.
// Function
// - Phase delay, ten signed bits in config bits 15:6, resets to zero.
// - Config bit 2 set disables the highpass filter; clear follows the global setting.
// - Config bits 1:0 select normal, shorted, positive or negative test input.
// - Upper offset word holds offset bits 23:8, read/write, resets zero.
// - Lower offset word bits 15:8 hold offset bits 7:0, read/write, reset zero.
// - Upper gain word holds gain bits 23:8 and resets to 8000h.
// - Lower gain word bits 15:8 hold gain bits 7:0, read/write, reset zero.
// - Low byte of both lower calibration words always reads zero.
// - Read-only checksum word at index 3Eh, resetting to zero.
// - Reserved word at index 3Fh, resetting to zero.
// - Config word at index Eh resets zero; bits 5:3 read zero.
module channel1_config_calib_regs (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [1:0]  avs_response,
	input  wire logic [3:0]  global_highpass_setting,
	output logic      [9:0]  second_channel_phase_delay,
	output logic             second_channel_highpass_disable,
	output logic      [3:0]  second_channel_highpass_setting,
	output logic      [1:0]  second_channel_input_select,
	output logic      [23:0] second_channel_offset,
	output logic      [23:0] second_channel_gain,
	output logic      [15:0] register_map_checksum,
	output logic             checksum_busy
);

	typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;

	localparam int NSLOT = ch1_regs_pkg::SLOT_COUNT;

	function automatic logic [2:0] slot_of(input logic [5:0] idx);
		case (idx)
			ch1_regs_pkg::IDX_CONFIG:       slot_of = ch1_regs_pkg::SLOT_CONFIG;
			ch1_regs_pkg::IDX_OFFSET_UPPER: slot_of = ch1_regs_pkg::SLOT_OFFSET_UPPER;
			ch1_regs_pkg::IDX_OFFSET_LOWER: slot_of = ch1_regs_pkg::SLOT_OFFSET_LOWER;
			ch1_regs_pkg::IDX_GAIN_UPPER:   slot_of = ch1_regs_pkg::SLOT_GAIN_UPPER;
			ch1_regs_pkg::IDX_GAIN_LOWER:   slot_of = ch1_regs_pkg::SLOT_GAIN_LOWER;
			ch1_regs_pkg::IDX_RESERVED:     slot_of = ch1_regs_pkg::SLOT_RESERVED;
			default:                        slot_of = ch1_regs_pkg::SLOT_NONE;
		endcase
	endfunction

	function automatic logic [15:0] mask_of(input logic [2:0] slot);
		case (slot)
			ch1_regs_pkg::SLOT_CONFIG:       mask_of = ch1_regs_pkg::MASK_CONFIG;
			ch1_regs_pkg::SLOT_OFFSET_LOWER: mask_of = ch1_regs_pkg::MASK_LOWER;
			ch1_regs_pkg::SLOT_GAIN_LOWER:   mask_of = ch1_regs_pkg::MASK_LOWER;
			ch1_regs_pkg::SLOT_NONE:         mask_of = 16'h0000;
			default:                         mask_of = ch1_regs_pkg::MASK_FULL;
		endcase
	endfunction

	function automatic logic [15:0] reset_of(input logic [2:0] slot);
		case (slot)
			ch1_regs_pkg::SLOT_CONFIG:       reset_of = ch1_regs_pkg::RST_CONFIG;
			ch1_regs_pkg::SLOT_OFFSET_UPPER: reset_of = ch1_regs_pkg::RST_OFFSET_UPPER;
			ch1_regs_pkg::SLOT_OFFSET_LOWER: reset_of = ch1_regs_pkg::RST_OFFSET_LOWER;
			ch1_regs_pkg::SLOT_GAIN_UPPER:   reset_of = ch1_regs_pkg::RST_GAIN_UPPER;
			ch1_regs_pkg::SLOT_GAIN_LOWER:   reset_of = ch1_regs_pkg::RST_GAIN_LOWER;
			default:                         reset_of = ch1_regs_pkg::RST_RESERVED;
		endcase
	endfunction

	bus_state_t  st_r;
	bus_state_t  st_nxt;
	logic        wait_r;
	logic        wait_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [1:0]  resp_r;
	logic [1:0]  resp_nxt;
	logic [15:0] word_r [NSLOT];
	logic [15:0] word_nxt [NSLOT];
	logic        changed_r;
	logic        changed_nxt;
	logic [3:0]  hp_r;
	logic [3:0]  hp_nxt;
	logic [5:0]  idx;
	logic [2:0]  slot;
	logic        slot_ok;
	logic        mapped;
	logic        commit_wr;
	logic [15:0] old_word;
	logic [15:0] merged;
	logic [15:0] rd_word;
	logic [15:0] crc_word;
	logic        crc_busy;

	assign idx = avs_address[7:2];
	assign slot = slot_of(idx);
	assign slot_ok = (slot != ch1_regs_pkg::SLOT_NONE);
	assign mapped = slot_ok || (idx == ch1_regs_pkg::IDX_CHECKSUM);
	// A write lands only at the edge where the master sees waitrequest low.
	assign commit_wr = (st_r == BUS_ANSWER) && avs_write;
	assign old_word = slot_ok ? word_r[slot] : 16'h0000;

	word_merge #(
		.WORD_W (16)
	) u_merge (
		.old_word    (old_word),
		.write_data  (avs_writedata[15:0]),
		.lane_enable (avs_byteenable[1:0]),
		.write_mask  (mask_of(slot)),
		.merged      (merged)
	);

	always_comb
	begin
		rd_word = 16'h0000;
		if (slot_ok)
		begin
			rd_word = word_r[slot];
		end
		else if (idx == ch1_regs_pkg::IDX_CHECKSUM)
		begin
			rd_word = crc_word;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		wait_nxt = wait_r;
		rdata_nxt = rdata_r;
		resp_nxt = resp_r;
		case (st_r)
			BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					st_nxt = BUS_ANSWER;
					wait_nxt = 1'b0;
					resp_nxt = mapped ? ch1_regs_pkg::RESP_OKAY : ch1_regs_pkg::RESP_DECODEERROR;
					if (avs_read)
					begin
						rdata_nxt = {16'h0000, rd_word};
					end
				end
			end
			BUS_ANSWER:
			begin
				st_nxt = BUS_IDLE;
				wait_nxt = 1'b1;
			end
			default:
			begin
				st_nxt = BUS_IDLE;
				wait_nxt = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			resp_r <= ch1_regs_pkg::RESP_OKAY;
		end
		else
		begin
			st_r <= st_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			resp_r <= resp_nxt;
		end
	end

	always_comb
	begin
		word_nxt = word_r;
		changed_nxt = 1'b0;
		// Reserved bits are outside the mask and stay zero.
		if (commit_wr && slot_ok)
		begin
			word_nxt[slot] = merged;
			changed_nxt = (merged != word_r[slot]);
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < NSLOT; i++)
			begin
				word_r[i] <= reset_of(3'(i));
			end
			changed_r <= 1'b0;
		end
		else
		begin
			word_r <= word_nxt;
			changed_r <= changed_nxt;
		end
	end

	always_comb
	begin
		hp_nxt = global_highpass_setting;
		if (word_r[ch1_regs_pkg::SLOT_CONFIG][ch1_regs_pkg::HP_DISABLE_BIT])
		begin
			hp_nxt = ch1_regs_pkg::HP_OFF;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hp_r <= ch1_regs_pkg::HP_OFF;
		end
		else
		begin
			hp_r <= hp_nxt;
		end
	end

	// The walk covers all six writable words and takes one cycle per word.
	checksum_walker #(
		.WORD_W     (16),
		.WORD_COUNT (NSLOT)
	) u_walker (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.start    (changed_r),
		.words    (word_r),
		.checksum (crc_word),
		.busy     (crc_busy)
	);

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign avs_response = resp_r;
	assign second_channel_phase_delay =
		word_r[ch1_regs_pkg::SLOT_CONFIG][ch1_regs_pkg::PHASE_MSB:ch1_regs_pkg::PHASE_LSB];
	assign second_channel_highpass_disable = word_r[ch1_regs_pkg::SLOT_CONFIG][ch1_regs_pkg::HP_DISABLE_BIT];
	assign second_channel_highpass_setting = hp_r;
	assign second_channel_input_select =
		word_r[ch1_regs_pkg::SLOT_CONFIG][ch1_regs_pkg::SEL_MSB:ch1_regs_pkg::SEL_LSB];
	assign second_channel_offset = {word_r[ch1_regs_pkg::SLOT_OFFSET_UPPER],
		word_r[ch1_regs_pkg::SLOT_OFFSET_LOWER][ch1_regs_pkg::LOWER_MSB:ch1_regs_pkg::LOWER_LSB]};
	assign second_channel_gain = {word_r[ch1_regs_pkg::SLOT_GAIN_UPPER],
		word_r[ch1_regs_pkg::SLOT_GAIN_LOWER][ch1_regs_pkg::LOWER_MSB:ch1_regs_pkg::LOWER_LSB]};
	assign register_map_checksum = crc_word;
	assign checksum_busy = crc_busy;

	chk_phase_write: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_CONFIG && avs_byteenable[1:0] == 2'h3
		|=> second_channel_phase_delay == $past(avs_writedata[15:6]))
		else $error("Phase delay does not follow the written config word.");

	chk_highpass_follow: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |-> second_channel_highpass_setting ==
		($past(second_channel_highpass_disable) ? 4'h0 : $past(global_highpass_setting)))
		else $error("Highpass setting ignores the channel disable bit.");

	chk_select_write: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_CONFIG && avs_byteenable[0]
		|=> second_channel_input_select == $past(avs_writedata[1:0]) && second_channel_highpass_disable ==
		$past(avs_writedata[2]))
		else $error("Input select does not follow the written config word.");

	chk_offset_upper: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_OFFSET_UPPER && avs_byteenable[1:0] == 2'h3
		|=> second_channel_offset[23:8] == $past(avs_writedata[15:0]) && $stable(second_channel_offset[7:0]))
		else $error("Upper offset write went wrong.");

	chk_offset_lower: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_OFFSET_LOWER && avs_byteenable[1]
		|=> second_channel_offset[7:0] == $past(avs_writedata[15:8]))
		else $error("Lower offset write went wrong.");

	chk_gain_reset: assert property (@(posedge clk)
		$fell(sys_rst) |-> second_channel_gain == 24'h800000 && second_channel_offset == 24'h000000)
		else $error("Calibration words leave reset with wrong values.");

	chk_gain_lower: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_GAIN_LOWER && avs_byteenable[1]
		|=> second_channel_gain[7:0] == $past(avs_writedata[15:8]) && $stable(second_channel_gain[23:8]))
		else $error("Lower gain write went wrong.");

	chk_lower_zero: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == BUS_ANSWER && avs_read &&
		(idx == ch1_regs_pkg::IDX_OFFSET_LOWER || idx == ch1_regs_pkg::IDX_GAIN_LOWER)
		|-> !avs_waitrequest && avs_readdata[7:0] == 8'h00)
		else $error("Reserved low byte of a lower word read non-zero.");

	chk_checksum_read: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == BUS_IDLE && avs_read && idx == ch1_regs_pkg::IDX_CHECKSUM
		|=> avs_readdata == {16'h0000, $past(register_map_checksum)} && avs_response == 2'h0)
		else $error("Checksum read returned the wrong word.");

	chk_checksum_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!$stable(register_map_checksum) |-> $past(checksum_busy) && !checksum_busy)
		else $error("Checksum changed outside the end of a walk.");

	chk_reserved_word: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && idx == ch1_regs_pkg::IDX_RESERVED && avs_byteenable[1:0] == 2'h3
		|=> word_r[ch1_regs_pkg::SLOT_RESERVED] ==
		$past(avs_writedata[15:0]))
		else $error("Reserved word does not hold its written value.");

	chk_config_rsvd: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == BUS_ANSWER && avs_read && idx == ch1_regs_pkg::IDX_CONFIG
		|-> avs_readdata[5:3] == 3'h0 && avs_readdata[31:16] == 16'h0000)
		else $error("Reserved config bits read non-zero.");

	chk_walk_start: assert property (@(posedge clk) disable iff (sys_rst)
		commit_wr && slot_ok && merged != old_word |=> ##1 checksum_busy [*6] ##1 !checksum_busy || changed_r)
		else $error("Checksum walk did not follow a register change.");

	chk_bus_answer: assert property (@(posedge clk) disable iff (sys_rst)
		st_r == BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("Bus answer is not exactly one cycle after the request.");

endmodule

// ### logic/checksum_walker.sv
/*
 * Walks a set of words one per cycle through a bitwise CRC and stores the result.
 * Assumes the words are stable flops of the same clock; a new start restarts the walk.
 */
module checksum_walker #(
	parameter int                 WORD_W     = 16,
	parameter int                 WORD_COUNT = 6,
	parameter logic [WORD_W-1:0]  POLY       = ch1_regs_pkg::CRC_POLY,
	parameter logic [WORD_W-1:0]  INIT       = ch1_regs_pkg::CRC_INIT
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              start,
	input  wire logic [WORD_W-1:0] words [WORD_COUNT],
	output logic      [WORD_W-1:0] checksum,
	output logic                   busy
);

	localparam int IDX_W = $clog2(WORD_COUNT);
	localparam logic [IDX_W-1:0] LAST = IDX_W'(WORD_COUNT - 1);

	function automatic logic [WORD_W-1:0] crc_step(input logic [WORD_W-1:0] acc, input logic [WORD_W-1:0] word);
		logic [WORD_W-1:0] a;
		logic              fb;
		a = acc;
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			fb = a[WORD_W-1] ^ word[i];
			a = {a[WORD_W-2:0], 1'b0};
			if (fb)
			begin
				a = a ^ POLY;
			end
		end
		return a;
	endfunction

	logic              busy_r;
	logic              busy_nxt;
	logic [IDX_W-1:0]  idx_r;
	logic [IDX_W-1:0]  idx_nxt;
	logic [WORD_W-1:0] acc_r;
	logic [WORD_W-1:0] acc_nxt;
	logic [WORD_W-1:0] crc_r;
	logic [WORD_W-1:0] crc_nxt;
	logic [WORD_W-1:0] step;

	always_comb
	begin
		busy_nxt = busy_r;
		idx_nxt = idx_r;
		acc_nxt = acc_r;
		crc_nxt = crc_r;
		step = crc_step(acc_r, words[idx_r]);
		// A change during a walk restarts it, so the stored result never misses a change.
		if (start)
		begin
			busy_nxt = 1'b1;
			idx_nxt = '0;
			acc_nxt = INIT;
		end
		else if (busy_r)
		begin
			if (idx_r == LAST)
			begin
				crc_nxt = step;
				busy_nxt = 1'b0;
			end
			else
			begin
				acc_nxt = step;
				idx_nxt = IDX_W'(idx_r + 1'b1);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busy_r <= 1'b0;
			idx_r <= '0;
			acc_r <= '0;
			crc_r <= ch1_regs_pkg::RST_CHECKSUM;
		end
		else
		begin
			busy_r <= busy_nxt;
			idx_r <= idx_nxt;
			acc_r <= acc_nxt;
			crc_r <= crc_nxt;
		end
	end

	assign checksum = crc_r;
	assign busy = busy_r;

endmodule

// ### logic/word_merge.sv
/*
 * Byte-lane write merge of one register word under a mask of writable bits.
 * Assumes lane enables come straight from the bus byte enables.
 */
module word_merge #(
	parameter int WORD_W = 16
) (
	input  wire logic [WORD_W-1:0]   old_word,
	input  wire logic [WORD_W-1:0]   write_data,
	input  wire logic [WORD_W/8-1:0] lane_enable,
	input  wire logic [WORD_W-1:0]   write_mask,
	output logic      [WORD_W-1:0]   merged
);

	logic [WORD_W-1:0] candidate;

	always_comb
	begin
		candidate = old_word;
		for (int i = 0; i < WORD_W / 8; i++)
		begin
			if (lane_enable[i])
			begin
				candidate[i*8 +: 8] = write_data[i*8 +: 8];
			end
		end
		// Read-only bits keep their old value so a write never sets them.
		merged = (candidate & write_mask) | (old_word & ~write_mask);
	end

endmodule
